// ---- scts_pkg.sv ----
/*
  Shared constants and types of the serial control target block.
  Assumes an 8-bit register space behind a two-wire target.
*/
package scts_pkg;

  // ----------------------------------------------------------------
  // Register offsets, reset values and write masks
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_ADDR_SELECT = 8'h00;
  localparam logic [7:0] REG_RESET_CTRL = 8'h01;
  localparam logic [7:0] REG_GEN_CFG = 8'h03;
  localparam logic [7:0] ADDR_SELECT_RST = 8'h00;
  localparam logic [7:0] RESET_CTRL_RST = 8'h00;
  localparam logic [7:0] GEN_CFG_RST = 8'hd2;
  localparam logic [7:0] RESET_CTRL_WMASK = 8'h80;
  localparam logic [7:0] GEN_CFG_WMASK = 8'hbb;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_ADDR_SRC = 0;
  localparam int BIT_PWR_AUTO = 7;
  localparam int BIT_FULL_RST = 1;
  localparam int BIT_LOGIC_RST = 0;
  localparam int BIT_CRC_EN = 7;
  localparam int BIT_AUTO_ACK = 5;
  localparam int BIT_FILTER = 4;
  localparam int BIT_PASS = 3;
  localparam int BIT_PCLK_AUTO = 1;
  localparam int BIT_EDGE_SEL = 0;

  // ----------------------------------------------------------------
  // Strap decode and bus framing
  // ----------------------------------------------------------------
  localparam int STRAP_COUNT = 9;
  localparam logic [6:0] STRAP_ADDR [0:8] = '{7'h0c, 7'h0d, 7'h0e,
    7'h0f, 7'h10, 7'h13, 7'h14, 7'h15, 7'h1b};
  localparam logic [1:0] STRAP_SETTLE = 2'h3;
  localparam logic [3:0] BIT_LAST = 4'h8;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_ADDR = 7'h02,
    ST_ADDR_ACK = 7'h04,
    ST_WDATA = 7'h08,
    ST_WACK = 7'h10,
    ST_RDATA = 7'h20,
    ST_RACK = 7'h40
  } scts_state_t;

endpackage

// ---- scts_pix_if.sv ----
/*
  Bundle between the control block and the pixel input stage.
  Config levels come from the system clock domain; the stage
  resynchronises them onto the pixel clock.
*/
`timescale 1ns/1ps
interface scts_pix_if;
  logic filter_en;
  logic edge_rise;
  logic [2:0] raw;
  logic [2:0] filt;

  modport filter (input filter_en, input edge_rise, input raw,
    output filt);
  modport ctrl (output filter_en, output edge_rise, output raw,
    input filt);
endinterface

// ---- scts_sync.sv ----
/*
  Two flip-flop level synchroniser, one per bit.
  Assumes inputs are levels that hold for several clock periods.
*/
`timescale 1ns/1ps
module scts_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_r;

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_r <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

// ---- scts_pix_filter.sv ----
/*
  Pixel input stage on the pixel clock: edge select and a two
  cycle glitch filter on the valid and sync inputs.
  Assumes the raw inputs are synchronous to the pixel clock.
*/
`timescale 1ns/1ps
module scts_pix_filter
  import scts_pkg::*;
#(
  parameter int WIDTH = 3
) (
  input wire logic pix_clk,
  input wire logic rst_b,
  scts_pix_if.filter pif
);
  logic [1:0] rst_sh_r;
  logic rst_pix_b;
  logic [1:0] cfg_s;
  logic [WIDTH-1:0] rise_r;
  logic [WIDTH-1:0] fall_r;
  logic [WIDTH-1:0] sample;
  logic [WIDTH-1:0] prev_r;
  logic [WIDTH-1:0] out_r;

  // ----------------------------------------------------------------
  // Reset release and config crossing
  // ----------------------------------------------------------------
  // Release the local reset in step with the pixel clock
  always_ff @(posedge pix_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_sh_r <= 2'h0;
    end else begin
      rst_sh_r <= {rst_sh_r[0], 1'b1};
    end
  end
  assign rst_pix_b = rst_sh_r[1];

  scts_sync #(
    .WIDTH(2),
    .RST_VAL({GEN_CFG_RST[BIT_FILTER], GEN_CFG_RST[BIT_EDGE_SEL]})
  ) u_cfg_sync (
    .clk(pix_clk),
    .rst_b(rst_pix_b),
    .d({pif.filter_en, pif.edge_rise}),
    .q(cfg_s)
  );

  // ----------------------------------------------------------------
  // Sampling on either edge
  // ----------------------------------------------------------------
  // Rising edge capture
  always_ff @(posedge pix_clk or negedge rst_pix_b) begin
    if (!rst_pix_b) begin
      rise_r <= '0;
    end else begin
      rise_r <= pif.raw;
    end
  end

  // Falling edge capture, read half a cycle later
  always_ff @(negedge pix_clk or negedge rst_pix_b) begin
    if (!rst_pix_b) begin
      fall_r <= '0;
    end else begin
      fall_r <= pif.raw;
    end
  end

  assign sample = cfg_s[0] ? rise_r : fall_r;

  // ----------------------------------------------------------------
  // Two cycle filter, one copy per input
  // ----------------------------------------------------------------
  for (genvar g = 0; g < WIDTH; g++) begin : g_filt
    // With the filter on, a new level passes only once seen on two samples in a row
    always_ff @(posedge pix_clk or negedge rst_pix_b) begin
      if (!rst_pix_b) begin
        prev_r[g] <= 1'b0;
        out_r[g] <= 1'b0;
      end else begin
        prev_r[g] <= sample[g];
        if (!cfg_s[1] || sample[g] == prev_r[g]) begin
          out_r[g] <= sample[g];
        end
      end
    end
  end

  assign pif.filt = out_r;
endmodule

// ---- scts_target.sv ----
/*
  Two-wire control bus target with its address, reset and general
  configuration registers, and the pixel input stage.
  Assumes a bus master outside, pull-ups on both bus wires, a strap
  level decoder giving an index 1..9, and a free pixel clock.
*/
// Notes on behaviour
// - Bus address picked from nine strap settings
// - Strap index maps to the fixed address table
// - Bus wires only pulled low or released
// - Start condition opens address reception
// - Rising data with clock high ends transaction
// - Own address acknowledged, others except an auto-acked remote target left released
// - Each written data byte acknowledged
// - Register address overrides strap when selected
// - Auto power down without control link
// - Self-clearing reset of logic and registers
// - Self-clearing reset keeping register contents
// - Config resets to d2, bit7 CRC check
// - Remote writes acknowledged at once when enabled
// - Short valid and sync pulses rejected
// - Config bit enables remote pass-through
// - Oscillator takeover when pixel clock absent
// - Config bit picks pixel sampling edge
`timescale 1ns/1ps
module scts_target
  import scts_pkg::*;
#(
  parameter logic [6:0] REMOTE_TARGET_ADDR = 7'h40
) (
  input wire logic SYS_CLK,
  input wire logic RST_B,
  input wire logic PIX_CLK,
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  input wire logic [3:0] ADDRESS_STRAP_PIN,
  input wire logic LINK_DETECT,
  input wire logic PCLK_ABSENT,
  input wire logic PIXEL_VALID_IN,
  input wire logic HORIZONTAL_SYNC_IN,
  input wire logic VERTICAL_SYNC_IN,
  output logic PIXEL_VALID_OUT,
  output logic HSYNC_OUT,
  output logic VSYNC_OUT,
  output logic POWER_DOWN,
  output logic OSC_SELECT,
  output logic CRC_CHECK_EN,
  output logic PASS_THROUGH_EN,
  output logic REMOTE_AUTO_ACK,
  output logic DIGITAL_RESET
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  scts_state_t state_r;
  logic [1:0] bus_s;
  logic [1:0] bus_p_r;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic [3:0] strap_s;
  logic [1:0] stat_s;
  logic [1:0] strap_cnt_r;
  logic [6:0] strap_addr_r;
  logic [6:0] own_addr;
  logic [7:0] dev_id_r;
  logic [7:0] rst_ctl_r;
  logic [7:0] cfg_r;
  logic pend_full_r;
  logic pend_logic_r;
  logic fire_full_r;
  logic fire_logic_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] shift_r;
  logic [7:0] ptr_r;
  logic first_r;
  logic remote_r;
  logic mack_r;
  logic sda_oe_r;
  logic wr_en_r;
  logic [7:0] wr_addr_r;
  logic [7:0] wr_data_r;
  logic [7:0] rd_byte;
  logic addr_hit;
  logic remote_hit;
  logic pwr_dn_r;
  logic osc_sel_r;
  logic dig_rst_r;
  scts_pix_if pif ();

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Bus wires idle high through the pull-ups
  scts_sync #(.WIDTH(2), .RST_VAL(2'h3)) u_bus_sync (
    .clk(SYS_CLK),
    .rst_b(RST_B),
    .d({SCL_IN, SDA_IN}),
    .q(bus_s)
  );

  scts_sync #(.WIDTH(4), .RST_VAL(4'h0)) u_strap_sync (
    .clk(SYS_CLK),
    .rst_b(RST_B),
    .d(ADDRESS_STRAP_PIN),
    .q(strap_s)
  );

  scts_sync #(.WIDTH(2), .RST_VAL(2'h0)) u_stat_sync (
    .clk(SYS_CLK),
    .rst_b(RST_B),
    .d({LINK_DETECT, PCLK_ABSENT}),
    .q(stat_s)
  );

  // Delayed copy for edge detection
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      bus_p_r <= 2'h3;
    end else begin
      bus_p_r <= bus_s;
    end
  end

  // Clock edges and framing conditions
  assign scl_rise = !bus_p_r[1] && bus_s[1];
  assign scl_fall = bus_p_r[1] && !bus_s[1];
  assign start_seen = bus_p_r[1] && bus_s[1] && bus_p_r[0] &&
    !bus_s[0];
  assign stop_seen = bus_p_r[1] && bus_s[1] && !bus_p_r[0] &&
    bus_s[0];

  // ----------------------------------------------------------------
  // Address selection
  // ----------------------------------------------------------------
  function automatic logic [6:0] strap_map(input logic [3:0] idx);
    strap_map = STRAP_ADDR[0];
    for (int i = 0; i < STRAP_COUNT; i++) begin
      if (idx == 4'(i + 1)) begin
        strap_map = STRAP_ADDR[i];
      end
    end
  endfunction

  // Catch the strap once it has settled after reset release
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      strap_cnt_r <= 2'h0;
      strap_addr_r <= STRAP_ADDR[0];
    end else if (fire_full_r) begin
      strap_cnt_r <= 2'h0;
    end else if (strap_cnt_r != STRAP_SETTLE) begin
      strap_cnt_r <= strap_cnt_r + 2'h1;
      strap_addr_r <= strap_map(strap_s);
    end
  end

  assign own_addr = dev_id_r[BIT_ADDR_SRC] ? dev_id_r[7:1] :
    strap_addr_r;
  assign addr_hit = shift_r[7:1] == own_addr;
  assign remote_hit = cfg_r[BIT_PASS] && !shift_r[0] &&
    shift_r[7:1] == REMOTE_TARGET_ADDR;

  // ----------------------------------------------------------------
  // Bus engine
  // ----------------------------------------------------------------
  // Sample on rising clock, drive data on falling clock
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      state_r <= ST_IDLE;
      bit_cnt_r <= 4'h0;
      shift_r <= 8'h00;
      ptr_r <= 8'h00;
      first_r <= 1'b0;
      remote_r <= 1'b0;
      mack_r <= 1'b0;
      sda_oe_r <= 1'b0;
      wr_en_r <= 1'b0;
      wr_addr_r <= 8'h00;
      wr_data_r <= 8'h00;
    end else begin
      wr_en_r <= 1'b0;
      if (fire_full_r || fire_logic_r) begin
        state_r <= ST_IDLE;
        sda_oe_r <= 1'b0;
      end else if (stop_seen) begin
        state_r <= ST_IDLE;
        sda_oe_r <= 1'b0;
      end else if (start_seen) begin
        state_r <= ST_ADDR;
        bit_cnt_r <= 4'h0;
        sda_oe_r <= 1'b0;
      end else begin
        case (state_r)
          ST_ADDR, ST_WDATA: begin
            if (scl_rise) begin
              shift_r <= {shift_r[6:0], bus_s[0]};
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end else if (scl_fall && bit_cnt_r == BIT_LAST) begin
              if (state_r == ST_ADDR) begin
                remote_r <= remote_hit;
                first_r <= 1'b1;
                if (addr_hit ||
                    (remote_hit && cfg_r[BIT_AUTO_ACK])) begin
                  sda_oe_r <= 1'b1;
                  state_r <= ST_ADDR_ACK;
                end else begin
                  state_r <= ST_IDLE;
                end
              end else if (remote_r) begin
                sda_oe_r <= cfg_r[BIT_AUTO_ACK];
                state_r <= cfg_r[BIT_AUTO_ACK] ? ST_WACK : ST_IDLE;
              end else begin
                if (first_r) begin
                  ptr_r <= shift_r;
                  first_r <= 1'b0;
                end else begin
                  wr_en_r <= 1'b1;
                  wr_addr_r <= ptr_r;
                  wr_data_r <= shift_r;
                  ptr_r <= ptr_r + 8'h01;
                end
                sda_oe_r <= 1'b1;
                state_r <= ST_WACK;
              end
            end
          end
          ST_ADDR_ACK: begin
            if (scl_fall) begin
              bit_cnt_r <= 4'h0;
              if (shift_r[0]) begin
                shift_r <= rd_byte;
                ptr_r <= ptr_r + 8'h01;
                sda_oe_r <= !rd_byte[7];
                state_r <= ST_RDATA;
              end else begin
                sda_oe_r <= 1'b0;
                state_r <= ST_WDATA;
              end
            end
          end
          ST_WACK: begin
            if (scl_fall) begin
              sda_oe_r <= 1'b0;
              bit_cnt_r <= 4'h0;
              state_r <= ST_WDATA;
            end
          end
          ST_RDATA: begin
            if (scl_rise) begin
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end else if (scl_fall) begin
              if (bit_cnt_r == BIT_LAST) begin
                sda_oe_r <= 1'b0;
                state_r <= ST_RACK;
              end else begin
                shift_r <= {shift_r[6:0], 1'b0};
                sda_oe_r <= !shift_r[6];
              end
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              mack_r <= !bus_s[0];
            end else if (scl_fall) begin
              bit_cnt_r <= 4'h0;
              if (mack_r) begin
                shift_r <= rd_byte;
                ptr_r <= ptr_r + 8'h01;
                sda_oe_r <= !rd_byte[7];
                state_r <= ST_RDATA;
              end else begin
                state_r <= ST_IDLE;
              end
            end
          end
          ST_IDLE: begin
            sda_oe_r <= 1'b0;
          end
          default: begin
            state_r <= ST_IDLE;
            sda_oe_r <= 1'b0;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  // Read mux at the current pointer
  always_comb begin
    rd_byte = 8'h00;
    case (ptr_r)
      REG_ADDR_SELECT: rd_byte = dev_id_r;
      REG_RESET_CTRL: rd_byte = rst_ctl_r |
        {6'h00, pend_full_r, pend_logic_r};
      REG_GEN_CFG: rd_byte = cfg_r;
      default: rd_byte = 8'h00;
    endcase
  end

  // Stored fields; reserved bits keep their reset value
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      dev_id_r <= ADDR_SELECT_RST;
      rst_ctl_r <= RESET_CTRL_RST;
      cfg_r <= GEN_CFG_RST;
    end else if (fire_full_r) begin
      dev_id_r <= ADDR_SELECT_RST;
      rst_ctl_r <= RESET_CTRL_RST;
      cfg_r <= GEN_CFG_RST;
    end else if (wr_en_r) begin
      case (wr_addr_r)
        REG_ADDR_SELECT: dev_id_r <= wr_data_r;
        REG_RESET_CTRL: rst_ctl_r <= wr_data_r & RESET_CTRL_WMASK;
        REG_GEN_CFG: cfg_r <= (wr_data_r & GEN_CFG_WMASK) |
          (cfg_r & ~GEN_CFG_WMASK);
        default: ;
      endcase
    end
  end

  // Reset requests wait for the bus to go idle so the ack completes
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      pend_full_r <= 1'b0;
      pend_logic_r <= 1'b0;
      fire_full_r <= 1'b0;
      fire_logic_r <= 1'b0;
    end else begin
      fire_full_r <= 1'b0;
      fire_logic_r <= 1'b0;
      if (wr_en_r && wr_addr_r == REG_RESET_CTRL) begin
        pend_full_r <= pend_full_r || wr_data_r[BIT_FULL_RST];
        pend_logic_r <= pend_logic_r || wr_data_r[BIT_LOGIC_RST];
      end else if (state_r == ST_IDLE) begin
        fire_full_r <= pend_full_r;
        fire_logic_r <= pend_logic_r;
        pend_full_r <= 1'b0;
        pend_logic_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Status driven outputs
  // ----------------------------------------------------------------
  // Power and clock source decisions, plus reset pulse to the datapath
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      pwr_dn_r <= 1'b0;
      osc_sel_r <= 1'b0;
      dig_rst_r <= 1'b0;
    end else begin
      pwr_dn_r <= rst_ctl_r[BIT_PWR_AUTO] && !stat_s[1];
      osc_sel_r <= cfg_r[BIT_PCLK_AUTO] && stat_s[0];
      dig_rst_r <= fire_full_r || fire_logic_r;
    end
  end

  // ----------------------------------------------------------------
  // Pixel input stage
  // ----------------------------------------------------------------
  assign pif.filter_en = cfg_r[BIT_FILTER];
  assign pif.edge_rise = cfg_r[BIT_EDGE_SEL];
  assign pif.raw = {PIXEL_VALID_IN, HORIZONTAL_SYNC_IN,
    VERTICAL_SYNC_IN};

  scts_pix_filter #(.WIDTH(3)) u_pix (
    .pix_clk(PIX_CLK),
    .rst_b(RST_B),
    .pif(pif)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign SDA_OUT = 1'b0;
  assign SDA_OE = sda_oe_r;
  assign PIXEL_VALID_OUT = pif.filt[2];
  assign HSYNC_OUT = pif.filt[1];
  assign VSYNC_OUT = pif.filt[0];
  assign POWER_DOWN = pwr_dn_r;
  assign OSC_SELECT = osc_sel_r;
  assign CRC_CHECK_EN = cfg_r[BIT_CRC_EN];
  assign PASS_THROUGH_EN = cfg_r[BIT_PASS];
  assign REMOTE_AUTO_ACK = cfg_r[BIT_AUTO_ACK];
  assign DIGITAL_RESET = dig_rst_r;
endmodule

// ---- scts_host.sv ----
/*
  Two-wire bus master model for the serial control target.
  Assumes the bench resolves both wires with pull-ups.
*/
`timescale 1ns/1ps
module scts_host (
  input wire logic clk,
  input wire logic sda_w,
  output logic scl_oe,
  output logic sda_oe
);
  // ----------------------------------
  // Line drive and bus framing
  // ----------------------------------
  initial begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
  end
  // Pull low or release, then hold a third of a bit, 100 ns
  task automatic drv(input logic c, input logic d);
    scl_oe <= c;
    sda_oe <= d;
    repeat (10) @(posedge clk);
  endtask
  // Data falls while the clock is high
  task automatic start();
    drv(1'b1, sda_oe);
    drv(1'b1, 1'b0);
    drv(1'b0, 1'b0);
    drv(1'b0, 1'b1);
    drv(1'b1, 1'b1);
  endtask
  // Data rises while the clock is high
  task automatic stop();
    drv(1'b1, sda_oe);
    drv(1'b1, 1'b1);
    drv(1'b0, 1'b1);
    drv(1'b0, 1'b0);
  endtask
  // Data changes only with the clock low; sampled late in high
  task automatic bt(input logic d, output logic s);
    drv(1'b1, sda_oe);
    drv(1'b1, !d);
    drv(1'b0, !d);
    s = sda_w;
  endtask
  // Byte out, MSB first, then the acknowledge slot
  task automatic wr(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bt(b[i], s);
    end
    bt(1'b1, s);
    ack = !s;
  endtask
  // Byte in; acknowledge all but the last
  task automatic rd(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bt(1'b1, b[i]);
    end
    bt(last, s);
  endtask
endmodule

// ---- scts_target_checker.sv ----
/*
  Checker for the serial control target: line use, framing,
  soft reset pulse and derived controls.
  Assumes it is bound to scts_target.
*/
`timescale 1ns/1ps
module scts_target_checker (
  input wire logic SYS_CLK,
  input wire logic RST_B,
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  input wire logic SDA_OUT,
  input wire logic SDA_OE,
  input wire logic LINK_DETECT,
  input wire logic PCLK_ABSENT,
  input wire logic POWER_DOWN,
  input wire logic OSC_SELECT,
  input wire logic DIGITAL_RESET
);
  // ----------
  // Properties
  // ----------
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RST_B);
  property p_od; SDA_OUT == 1'b0 && (!SDA_OE || !SDA_IN); endproperty
  a_od: assert property (p_od) else $error("sda driven high");
  property p_oe; $changed(SDA_OE) |-> !SCL_IN; endproperty
  a_oe: assert property (p_oe) else $error("sda moved, scl high");
  property p_start; $fell(SDA_IN) && SCL_IN |=> !SDA_OE [*8]; endproperty
  a_start: assert property (p_start) else $error("drive at start");
  property p_stop; $rose(SDA_IN) && SCL_IN |=> !SDA_OE [*8]; endproperty
  a_stop: assert property (p_stop) else $error("drive after stop");
  property p_pd; LINK_DETECT [*6] |-> !POWER_DOWN; endproperty
  a_pd: assert property (p_pd) else $error("power down with link");
  property p_osc; !PCLK_ABSENT [*6] |-> !OSC_SELECT; endproperty
  a_osc: assert property (p_osc) else $error("osc with pclk");
  property p_pulse;
    DIGITAL_RESET |-> SCL_IN && SDA_IN ##1 !DIGITAL_RESET;
  endproperty
  a_pulse: assert property (p_pulse) else $error("bad reset pulse");
  property p_quiet; DIGITAL_RESET |=> !SDA_OE [*4]; endproperty
  a_quiet: assert property (p_quiet) else $error("drive in reset");
  c_pd: cover property (POWER_DOWN);
  c_osc: cover property (OSC_SELECT);
  c_rst: cover property (DIGITAL_RESET);
endmodule
bind scts_target scts_target_checker scts_target_checker_inst (
  .SYS_CLK(SYS_CLK), .RST_B(RST_B), .SCL_IN(SCL_IN), .SDA_IN(SDA_IN),
  .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .LINK_DETECT(LINK_DETECT),
  .PCLK_ABSENT(PCLK_ABSENT), .POWER_DOWN(POWER_DOWN),
  .OSC_SELECT(OSC_SELECT), .DIGITAL_RESET(DIGITAL_RESET));

// ---- tb.sv ----
/*
  Testbench for the serial control target: addressing, registers,
  soft resets and pixel filter. Assumes the host model is compiled.
*/
`timescale 1ns/1ps
module tb;
  logic clk, pclk, rst_b, link, pabs, h_scl, h_sda;
  logic sda_oe, sda_out, pd, osc, crc, pte, raa, drst;
  logic [3:0] strap;
  logic [2:0] pin, pout;
  logic [6:0] me;
  int err_total, compares, npulse;
  // Open-drain wires with pull-ups
  wire scl_w = !h_scl;
  wire sda_w = !h_sda & (sda_oe ? sda_out : 1'b1);
  scts_host h (.clk(clk), .sda_w(sda_w), .scl_oe(h_scl), .sda_oe(h_sda));
  scts_target scts_target_inst (
    .SYS_CLK(clk), .RST_B(rst_b), .PIX_CLK(pclk), .SCL_IN(scl_w),
    .SDA_IN(sda_w), .SDA_OUT(sda_out), .SDA_OE(sda_oe),
    .ADDRESS_STRAP_PIN(strap), .LINK_DETECT(link), .PCLK_ABSENT(pabs),
    .PIXEL_VALID_IN(pin[2]), .HORIZONTAL_SYNC_IN(pin[1]),
    .VERTICAL_SYNC_IN(pin[0]), .PIXEL_VALID_OUT(pout[2]),
    .HSYNC_OUT(pout[1]), .VSYNC_OUT(pout[0]), .POWER_DOWN(pd),
    .OSC_SELECT(osc), .CRC_CHECK_EN(crc), .PASS_THROUGH_EN(pte),
    .REMOTE_AUTO_ACK(raa), .DIGITAL_RESET(drst));
  // Clocks, the pixel one offset in phase
  initial begin
    clk = 1'b0;
    forever #5 clk = !clk;
  end
  initial begin
    pclk = 1'b0;
    #3;
    forever #7.5 pclk = !pclk;
  end
  // Count soft reset pulses
  always @(posedge clk) if (drst) npulse++;
  // ------------------
  // Shared tasks
  // ------------------
  task automatic chk(input string n, input logic [7:0] e,
      input logic [7:0] g);
    compares++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", n, e, g);
      err_total++;
    end
  endtask
  task automatic conclude();
    if (err_total == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic do_reset();
    rst_b <= 1'b0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    repeat (6) @(posedge clk);
  endtask
  task automatic probe(input logic [6:0] a, input logic e);
    logic k;
    h.start();
    h.wr({a, 1'b0}, k);
    h.stop();
    chk("addr_ack", {7'h0, e}, {7'h0, k});
  endtask
  task automatic wreg(input logic [7:0] r, input logic [7:0] d);
    logic [2:0] k;
    h.start();
    h.wr({me, 1'b0}, k[2]);
    h.wr(r, k[1]);
    h.wr(d, k[0]);
    h.stop();
    chk("write_acks", 8'h07, {5'h0, k});
  endtask
  task automatic rreg(input logic [7:0] r, input logic [7:0] e);
    logic k;
    logic [7:0] v;
    h.start();
    h.wr({me, 1'b0}, k);
    h.wr(r, k);
    h.start();
    h.wr({me, 1'b1}, k);
    h.rd(1'b1, v);
    h.stop();
    chk("read_data", e, v);
  endtask
  // ------------------
  // Scenarios
  // ------------------
  task automatic t_strap();
    logic [6:0] tbl [9] = '{7'h0c, 7'h0d, 7'h0e, 7'h0f, 7'h10,
      7'h13, 7'h14, 7'h15, 7'h1b};
    for (int i = 0; i < 9; i++) begin
      strap <= 4'(i + 1);
      do_reset();
      probe(tbl[i], 1'b1);
      probe(7'h11, 1'b0);
    end
    strap <= 4'h1;
    do_reset();
  endtask
  task automatic t_reset();
    logic k;
    logic [7:0] v [4];
    h.start();
    h.wr({me, 1'b0}, k);
    h.wr(8'h00, k);
    h.start();
    h.wr({me, 1'b1}, k);
    for (int i = 0; i < 4; i++) begin
      h.rd(i == 3, v[i]);
    end
    h.stop();
    chk("reg00", 8'h00, v[0]);
    chk("reg01", 8'h00, v[1]);
    chk("unmapped", 8'h00, v[2]);
    chk("reg03", 8'hd2, v[3]);
  endtask
  task automatic t_cfg();
    wreg(8'h03, 8'h00);
    rreg(8'h03, 8'h40);
    chk("cfg_lo", 8'h00, {5'h0, crc, pte, raa});
    probe(7'h40, 1'b0);
    wreg(8'h03, 8'hff);
    rreg(8'h03, 8'hfb);
    chk("cfg_hi", 8'h07, {5'h0, crc, pte, raa});
    probe(7'h40, 1'b1);
  endtask
  task automatic t_ctrl();
    wreg(8'h01, 8'hfc);
    rreg(8'h01, 8'h80);
    link <= 1'b0;
    pabs <= 1'b1;
    repeat (8) @(posedge clk);
    chk("pd_osc_on", 8'h03, {6'h0, pd, osc});
    link <= 1'b1;
    wreg(8'h03, 8'hf9);
    chk("pd_osc_off", 8'h00, {6'h0, pd, osc});
    pabs <= 1'b0;
  endtask
  task automatic t_sel();
    wreg(8'h00, 8'h45);
    me = 7'h22;
    probe(7'h0c, 1'b0);
    rreg(8'h00, 8'h45);
    wreg(8'h00, 8'h44);
    me = 7'h0c;
    rreg(8'h00, 8'h44);
  endtask
  task automatic t_soft();
    int n;
    n = npulse;
    wreg(8'h01, 8'h81);
    chk("pulse_keep", 8'(n + 1), 8'(npulse));
    rreg(8'h03, 8'hf9);
    wreg(8'h01, 8'h02);
    chk("pulse_full", 8'(n + 2), 8'(npulse));
    rreg(8'h01, 8'h00);
    rreg(8'h03, 8'hd2);
  endtask
  task automatic pulse(input int n, input logic [2:0] e, input string s);
    logic [2:0] seen;
    seen = 3'h0;
    @(posedge pclk);
    pin <= 3'h7;
    repeat (n) @(posedge pclk);
    pin <= 3'h0;
    repeat (8) begin
      @(posedge pclk);
      seen = seen | pout;
    end
    chk(s, {5'h0, e}, {5'h0, seen});
  endtask
  // One pixel period pulse; falling capture shows by mid next cycle
  task automatic edge_probe(input logic [2:0] e, input string s);
    @(posedge pclk);
    pin <= 3'h7;
    @(posedge pclk);
    pin <= 3'h0;
    @(negedge pclk);
    chk(s, {5'h0, e}, {5'h0, pout});
    repeat (4) @(posedge pclk);
  endtask
  task automatic t_pix();
    pulse(1, 3'h0, "filt_short");
    pulse(2, 3'h7, "filt_long");
    wreg(8'h03, 8'h81);
    repeat (10) @(posedge pclk);
    pulse(1, 3'h7, "rise_short");
    edge_probe(3'h0, "edge_rise");
    wreg(8'h03, 8'h80);
    repeat (10) @(posedge pclk);
    edge_probe(3'h7, "edge_fall");
  endtask
  // Main sequence
  initial begin
    rst_b = 1'b0;
    link = 1'b1;
    pabs = 1'b0;
    strap = 4'h1;
    pin = 3'h0;
    me = 7'h0c;
    err_total = 0;
    compares = 0;
    npulse = 0;
    t_strap();
    t_reset();
    t_cfg();
    t_ctrl();
    t_sel();
    t_soft();
    t_pix();
    conclude();
  end
  // Hang limit
  initial begin
    repeat (90000) @(posedge clk);
    err_total++;
    conclude();
  end
endmodule
